/* core/ret_rot_exec.sv */
// Overview of operation
// - interrupt return pops stack, loads PC
// - interrupt return sets enable bit 7, flags kept
// - interrupt return: one word, two cycles
// - subroutine return pops stack, no flags
// - subroutine return takes two cycles
// - literal return writes 8-bit literal, flags kept
// - literal return loads PC from stack top
// - literal return: one word, two cycles
// - rotate left through carry, carry only
// - destination 0 to W, 1 to file
// - rotate addresses 0..127, one cycle
`timescale 1ns/1ps
module ret_rot_exec
  import ret_rot_pkg::*;
#(
  parameter int PC_W = PC_W_DEF,
  parameter int ICYC_CLKS = CLKS_PER_ICYC
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire op_t op_code,
  input wire logic [DATA_W-1:0] op_literal,
  input wire logic [FADDR_W-1:0] op_faddr,
  input wire logic op_dest,
  input wire logic [PC_W-1:0] top_of_stack,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic carry_in,
  output logic op_ready,
  output logic busy,
  output logic done,
  output logic stack_pop,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  output logic w_we,
  output logic [DATA_W-1:0] w_data,
  output logic file_we,
  output logic [FADDR_W-1:0] file_addr,
  output logic [DATA_W-1:0] file_wdata,
  output logic carry_we,
  output logic carry_value,
  output logic interrupt_control_reg_set_we,
  output logic [DATA_W-1:0] interrupt_control_reg_set_mask
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_pipe_q;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_pipe_q <= 2'h0;
    end
    else
    begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  exec_link_if lnk ();

  icyc_timer #(.CLKS(ICYC_CLKS)) u_timer (
    .sys_clk(sys_clk),
    .rst_sync_n(rst_sync_n),
    .clk_en(clk_en),
    .lnk(lnk)
  );

  rot_left_unit u_rot (
    .lnk(lnk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    exec_state_t st;
    op_t op;
    logic [DATA_W-1:0] lit;
    logic [FADDR_W-1:0] fa;
    logic dest;
    logic icyc;
    logic done;
    logic pop;
    logic pcl;
    logic [PC_W-1:0] pc;
    logic wwe;
    logic [DATA_W-1:0] wdat;
    logic fwe;
    logic [DATA_W-1:0] fdat;
    logic cwe;
    logic cval;
    logic global_interrupt_enable;
  } exec_t;

  exec_t q, d;
  logic accept;
  logic last_icyc;

  assign op_ready = (q.st == ST_IDLE);
  assign accept = op_valid && op_ready && (op_code != OP_NONE);
  assign last_icyc = (int'(q.icyc) == op_icycs(q.op) - 1);
  assign lnk.run = (q.st == ST_EXEC);
  // operand must be stable from accept to end of the cycle
  assign lnk.rot_in = file_rdata;
  assign lnk.rot_cin = carry_in;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.pop = 1'b0;
    d.pcl = 1'b0;
    d.wwe = 1'b0;
    d.fwe = 1'b0;
    d.cwe = 1'b0;
    d.global_interrupt_enable = 1'b0;
    case (q.st)
      ST_IDLE:
      begin
        if (accept)
        begin
          d.st = ST_EXEC;
          d.op = op_code;
          d.lit = op_literal;
          d.fa = op_faddr;
          d.dest = op_dest;
          d.icyc = 1'b0;
        end
      end
      ST_EXEC:
      begin
        if (lnk.cyc_end)
        begin
          // returns act at end of first cycle; second cycle refills the fetch
          if (!q.icyc && q.op != OP_ROT_LEFT)
          begin
            d.pop = 1'b1;
            d.pcl = 1'b1;
            d.pc = top_of_stack;
            if (q.op == OP_RET_INT)
            begin
              d.global_interrupt_enable = 1'b1;
            end
            if (q.op == OP_RET_LIT)
            begin
              d.wwe = 1'b1;
              d.wdat = q.lit;
            end
          end
          if (q.op == OP_ROT_LEFT)
          begin
            d.cwe = 1'b1;
            d.cval = lnk.rot_cout;
            if (q.dest == DEST_WREG)
            begin
              d.wwe = 1'b1;
              d.wdat = lnk.rot_out;
            end
            else
            begin
              d.fwe = 1'b1;
              d.fdat = lnk.rot_out;
            end
          end
          if (last_icyc)
          begin
            d.done = 1'b1;
            d.st = ST_IDLE;
          end
          else
          begin
            d.icyc = 1'b1;
          end
        end
      end
      default:
      begin
        d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      q <= '0;
    end
    else if (clk_en)
    begin
      q <= d;
    end
  end

  assign busy = (q.st == ST_EXEC);
  assign done = q.done;
  assign stack_pop = q.pop;
  assign pc_load = q.pcl;
  assign pc_value = q.pc;
  assign w_we = q.wwe;
  assign w_data = q.wdat;
  assign file_we = q.fwe;
  assign file_addr = q.fa;
  assign file_wdata = q.fdat;
  assign carry_we = q.cwe;
  assign carry_value = q.cval;
  assign interrupt_control_reg_set_we = q.global_interrupt_enable;
  // only the global enable bit is ever set; status flags untouched
  assign interrupt_control_reg_set_mask = q.global_interrupt_enable ? GIE_MASK : ZERO_BYTE;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [15:0] elapsed_q;

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      elapsed_q <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (accept)
      begin
        elapsed_q <= 16'h0000;
      end
      else if (busy)
      begin
        elapsed_q <= elapsed_q + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_n);

  property p_pop_loads_pc;
    $rose(pc_load) |-> stack_pop && pc_value == $past(top_of_stack);
  endproperty
  a_pop_loads_pc: assert property (p_pop_loads_pc) else $error("pc not loaded from stack top");

  property p_gie_only;
    $rose(interrupt_control_reg_set_we) |-> interrupt_control_reg_set_mask[GIE_BIT] && stack_pop && !carry_we && q.op == OP_RET_INT;
  endproperty
  a_gie_only: assert property (p_gie_only) else $error("enable set wrong");

  property p_ret_int_len;
    $rose(done) && q.op == OP_RET_INT |-> elapsed_q == 16'(RET_ICYCS * ICYC_CLKS);
  endproperty
  a_ret_int_len: assert property (p_ret_int_len) else $error("interrupt return length wrong");

  property p_ret_sub_clean;
    $rose(pc_load) && q.op == OP_RET_SUB |-> !carry_we && !interrupt_control_reg_set_we && !w_we && !file_we;
  endproperty
  a_ret_sub_clean: assert property (p_ret_sub_clean) else $error("subroutine return side effect");

  property p_ret_sub_len;
    $rose(done) && q.op == OP_RET_SUB |-> elapsed_q == 16'(RET_ICYCS * ICYC_CLKS);
  endproperty
  a_ret_sub_len: assert property (p_ret_sub_len) else $error("subroutine return length wrong");

  property p_lit_to_w;
    $rose(w_we) && q.op == OP_RET_LIT |-> w_data == q.lit && !carry_we && pc_load;
  endproperty
  a_lit_to_w: assert property (p_lit_to_w) else $error("literal return wrong");

  property p_lit_len;
    $rose(done) && q.op == OP_RET_LIT |-> elapsed_q == 16'(RET_ICYCS * ICYC_CLKS);
  endproperty
  a_lit_len: assert property (p_lit_len) else $error("literal return length wrong");

  property p_rot_carry_only;
    $rose(carry_we) |-> q.op == OP_ROT_LEFT && !pc_load && !interrupt_control_reg_set_we && done;
  endproperty
  a_rot_carry_only: assert property (p_rot_carry_only) else $error("rotate side effect");

  property p_rot_dest;
    $rose(carry_we) |-> (q.dest ? (file_we && !w_we && file_addr == q.fa) : (w_we && !file_we));
  endproperty
  a_rot_dest: assert property (p_rot_dest) else $error("rotate destination wrong");

  property p_rot_len;
    $rose(done) && q.op == OP_ROT_LEFT |-> elapsed_q == 16'(ROT_ICYCS * ICYC_CLKS);
  endproperty
  a_rot_len: assert property (p_rot_len) else $error("rotate length wrong");

  property p_rot_value;
    $rose(carry_we) |-> carry_value == $past(file_rdata[DATA_W-1])
      && (q.dest ? file_wdata : w_data) == {$past(file_rdata[DATA_W-2:0]), $past(carry_in)};
  endproperty
  a_rot_value: assert property (p_rot_value) else $error("rotate value wrong");

  property p_c_ret_int;
    $rose(done) && q.op == OP_RET_INT;
  endproperty
  c_ret_int: cover property (p_c_ret_int);

  property p_c_ret_lit;
    $rose(done) && q.op == OP_RET_LIT;
  endproperty
  c_ret_lit: cover property (p_c_ret_lit);

  property p_c_rot_file;
    $rose(file_we) && q.op == OP_ROT_LEFT;
  endproperty
  c_rot_file: cover property (p_c_rot_file);

  property p_c_rot_w;
    $rose(w_we) && q.op == OP_ROT_LEFT;
  endproperty
  c_rot_w: cover property (p_c_rot_w);

endmodule : ret_rot_exec

/* core/ret_rot_pkg.sv */
package ret_rot_pkg;

  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W_DEF = 16;
  // one instruction cycle spans this many core clocks
  localparam int CLKS_PER_ICYC = 4;
  localparam int RET_ICYCS = 2;
  localparam int ROT_ICYCS = 1;
  localparam int GIE_BIT = 7;
  localparam logic DEST_WREG = 1'h0;
  localparam logic DEST_FILE = 1'h1;
  localparam logic [DATA_W-1:0] GIE_MASK = 8'h80;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_RET_INT,
    OP_RET_SUB,
    OP_RET_LIT,
    OP_ROT_LEFT
  } op_t;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } exec_state_t;

  // instruction cycles an operation occupies
  function automatic int op_icycs(input op_t op);
    op_icycs = (op == OP_ROT_LEFT) ? ROT_ICYCS : RET_ICYCS;
  endfunction : op_icycs

endpackage : ret_rot_pkg

/* core/exec_link_if.sv */
`timescale 1ns/1ps
interface exec_link_if;
  logic run;
  logic cyc_end;
  logic [7:0] rot_in;
  logic rot_cin;
  logic [7:0] rot_out;
  logic rot_cout;

  modport ctrl (output run, input cyc_end, output rot_in, output rot_cin, input rot_out, input rot_cout);
  modport timer (input run, output cyc_end);
  modport rot (input rot_in, input rot_cin, output rot_out, output rot_cout);
endinterface : exec_link_if

/* core/icyc_timer.sv */
`timescale 1ns/1ps
module icyc_timer
  import ret_rot_pkg::*;
#(
  parameter int CLKS = CLKS_PER_ICYC
)(
  input wire logic sys_clk,
  input wire logic rst_sync_n,
  input wire logic clk_en,
  exec_link_if.timer lnk
);
  localparam int CW = (CLKS > 1) ? $clog2(CLKS) : 1;
  localparam logic [CW-1:0] LAST = CW'(CLKS - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;

  typedef struct packed {
    logic [CW-1:0] cnt;
  } tmr_t;

  tmr_t q, d;

  assign lnk.cyc_end = lnk.run && (q.cnt == LAST);

  always_comb
  begin
    d = q;
    if (!lnk.run || lnk.cyc_end)
    begin
      d.cnt = CNT_ZERO;
    end
    else
    begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      q <= '0;
    end
    else if (clk_en)
    begin
      q <= d;
    end
  end
endmodule : icyc_timer

/* core/rot_left_unit.sv */
`timescale 1ns/1ps
module rot_left_unit
  import ret_rot_pkg::*;
(
  exec_link_if.rot lnk
);
  // old carry enters bit 0, old bit 7 leaves as carry
  assign lnk.rot_out = {lnk.rot_in[DATA_W-2:0], lnk.rot_cin};
  assign lnk.rot_cout = lnk.rot_in[DATA_W-1];
endmodule : rot_left_unit

/* sim/core_model.sv */
`timescale 1ns/1ps
module core_model
  import ret_rot_pkg::*;
(
  input wire logic sys_clk,
  input wire logic stack_pop,
  input wire logic file_we,
  input wire logic [FADDR_W-1:0] file_addr,
  input wire logic [DATA_W-1:0] file_wdata,
  input wire logic carry_we,
  input wire logic carry_value,
  input wire logic interrupt_control_reg_set_we,
  input wire logic [DATA_W-1:0] interrupt_control_reg_set_mask,
  output logic [15:0] top_of_stack,
  output logic [DATA_W-1:0] file_rdata,
  output logic carry_in
);
  logic [DATA_W-1:0] mem [128];
  logic [15:0] tos_q = 16'h1230;
  logic c_q = 1'b0;
  logic [DATA_W-1:0] interrupt_control_reg_q = ZERO_BYTE;

  // uneven fill so every bit position sees both values
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i * 37 + 5);
  end

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    if (stack_pop)
      tos_q <= tos_q + 16'h0457;
    if (file_we)
      mem[file_addr] <= file_wdata;
    if (carry_we)
      c_q <= carry_value;
    if (interrupt_control_reg_set_we)
      interrupt_control_reg_q <= interrupt_control_reg_q | interrupt_control_reg_set_mask;
  end

  assign top_of_stack = tos_q;
  assign file_rdata = mem[file_addr];
  assign carry_in = c_q;
endmodule : core_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import ret_rot_pkg::*;
;
  localparam int IC = 4;
  typedef struct packed {
    logic pop;
    logic pcl;
    logic [15:0] pc;
    logic we_w;
    logic [7:0] wd;
    logic we_f;
    logic [6:0] fa;
    logic [7:0] fd;
    logic we_c;
    logic cv;
    logic we_i;
    logic [7:0] im;
  } obs_t;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  logic clk_en = 1'b1;
  logic stall = 1'b0;
  op_t op_code = OP_NONE;
  logic [7:0] op_literal = 8'h00;
  logic [6:0] op_faddr = 7'h00;
  logic op_dest = 1'b0;
  logic [15:0] top_of_stack;
  logic [15:0] pc_value;
  logic [7:0] file_rdata;
  logic [7:0] w_data;
  logic [7:0] file_wdata;
  logic [7:0] interrupt_control_reg_set_mask;
  logic [6:0] file_addr;
  logic carry_in, op_ready, busy, done, stack_pop, pc_load, w_we, file_we, carry_we, carry_value, interrupt_control_reg_set_we;
  obs_t exp_q[$];
  obs_t o;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  logic [15:0] rnd = 16'h3000;

  always #20 sys_clk = ~sys_clk;

  // clk_en dropped for one edge in some operations; the operation must stretch by that edge
  ret_rot_exec #(.PC_W(16), .ICYC_CLKS(IC)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .op_valid(op_valid), .op_code(op_code), .op_literal(op_literal), .op_faddr(op_faddr), .op_dest(op_dest),
    .top_of_stack(top_of_stack), .file_rdata(file_rdata), .carry_in(carry_in), .op_ready(op_ready),
    .busy(busy), .done(done), .stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value), .w_we(w_we),
    .w_data(w_data), .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata), .carry_we(carry_we),
    .carry_value(carry_value), .interrupt_control_reg_set_we(interrupt_control_reg_set_we), .interrupt_control_reg_set_mask(interrupt_control_reg_set_mask));

  core_model prt (.sys_clk(sys_clk), .stack_pop(stack_pop), .file_we(file_we), .file_addr(file_addr),
    .file_wdata(file_wdata), .carry_we(carry_we), .carry_value(carry_value), .interrupt_control_reg_set_we(interrupt_control_reg_set_we),
    .interrupt_control_reg_set_mask(interrupt_control_reg_set_mask), .top_of_stack(top_of_stack), .file_rdata(file_rdata),
    .carry_in(carry_in));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic fail(input string m);
    miscompares++;
    $display("ERROR %0t %s", $time, m);
  endtask : fail

  task automatic compare_obs(input obs_t got, input obs_t want);
    check_count++;
    if (got !== want)
      fail($sformatf("result %h want %h", got, want));
  endtask : compare_obs

  task automatic compare_cycles(input int got, input int want);
    check_count++;
    if (got != want)
      fail($sformatf("length %0d want %0d", got, want));
  endtask : compare_cycles

  task automatic compare_state(input logic [1:0] got, input logic [1:0] want);
    check_count++;
    if (got !== want)
      fail($sformatf("busy/ready %b want %b", got, want));
  endtask : compare_state

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail("timeout");
      summarize();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data fields masked when their strobe is low, since they hold old values
  always @(negedge sys_clk)
    // only the last cycle of a stretched pulse is taken, so each result is seen once
    if (rst_n && clk_en && (stack_pop | pc_load | w_we | file_we | carry_we | interrupt_control_reg_set_we) === 1'b1)
    begin
      o = {stack_pop, pc_load, pc_load ? pc_value : 16'h0000, w_we, w_we ? w_data : 8'h00, file_we,
        file_we ? file_addr : 7'h00, file_we ? file_wdata : 8'h00, carry_we, carry_we & carry_value,
        interrupt_control_reg_set_we, interrupt_control_reg_set_mask};
      if (exp_q.size() == 0)
        fail("unexpected result");
      else
        compare_obs(o, exp_q.pop_front());
    end

  // a refused request is offered in mid-operation to catch queueing
  task automatic run_op(input op_t op, input logic [7:0] k, input logic [6:0] f, input logic d);
    obs_t e;
    int n;
    logic [7:0] v;
    logic [7:0] r;
    while (op_ready !== 1'b1)
      @(negedge sys_clk);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= op;
    op_literal <= k;
    op_faddr <= f;
    op_dest <= d;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    @(negedge sys_clk);
    compare_state({busy, op_ready}, 2'b10);
    e = '0;
    v = prt.mem[f];
    r = {v[6:0], prt.c_q};
    if (op == OP_ROT_LEFT)
      e = {2'b00, 16'h0000, !d, d ? 8'h00 : r, d, d ? f : 7'h00, d ? r : 8'h00, 1'b1, v[7], 9'h000};
    else
      e = {2'b11, prt.tos_q, op == OP_RET_LIT, op == OP_RET_LIT ? k : 8'h00, 18'h00000,
        op == OP_RET_INT, op == OP_RET_INT ? GIE_MASK : ZERO_BYTE};
    exp_q.push_back(e);
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
      if (n == 1)
      begin
        op_valid <= 1'b1;
        op_code <= OP_RET_SUB;
      end
      if (n == 2)
      begin
        op_valid <= 1'b0;
        clk_en <= !stall;
      end
      if (n == 3)
        clk_en <= 1'b1;
      @(negedge sys_clk);
    end
    compare_cycles(n, (op == OP_ROT_LEFT ? ROT_ICYCS : RET_ICYCS) * IC + int'(stall));
    compare_state({busy, op_ready}, 2'b01);
  endtask : run_op

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // an empty operation code must not start anything
    op_valid <= 1'b1;
    op_code <= OP_NONE;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    @(negedge sys_clk);
    compare_state({busy, op_ready}, 2'b01);
    run_op(OP_RET_INT, 8'h00, 7'h00, 1'b0);
    run_op(OP_RET_SUB, 8'h5A, 7'h11, 1'b1);
    run_op(OP_RET_LIT, 8'h00, 7'h00, 1'b0);
    run_op(OP_RET_LIT, 8'hFF, 7'h00, 1'b0);
    run_op(OP_ROT_LEFT, 8'h00, 7'h00, 1'b0);
    run_op(OP_ROT_LEFT, 8'h00, 7'h7F, 1'b1);
    run_op(OP_ROT_LEFT, 8'h00, 7'h7F, 1'b1);
    repeat (40)
    begin
      rnd = lfsr(rnd);
      stall = rnd[3];
      run_op(op_t'(3'(rnd[1:0]) + 3'h1), rnd[15:8], rnd[14:8], rnd[2]);
    end
    repeat (3) @(negedge sys_clk);
    check_count++;
    if (exp_q.size() != 0)
      fail("missing result");
    summarize();
  end
endmodule : tb_top
